// >>> scgc_device.sv
// Purpose: sample clock generator control registers and frame master
// Assumes: pclk at 40 MHz stands in for the master clock
// Notes: gen2 decode and gen1 flags lag their registers by one cycle
// Operation
// - gen1 mode resets 00FF, held in reset/power-down
// - rate register used only when master-clock referenced
// - one hertz per rate LSB
// - host keeps rate within 0x0FA0..0xD2F0
// - rate resets BB80, held in reset/power-down
// - low phase byte magnitude, 0.12 degrees each
// - magnitude decremented one LSB at 3.072 MHz
// - phase read returns remainder at slot 0
// - phase write replaces remaining shift
// - previous contents returned in next frame slot 1
// - phase cleared, protected unless gen1 enabled
// - host writes zero to reserved bits
// - gen2 reference clear: master clock, shiftable phase
// - gen2 reference set: sync lock, no shift
// - video-lock bit picks normal or video lock
// - loop gain bit: finite or infinite gain
// - plus-200 bit raises bit clock, not video
// - eight-sevenths bit, ignored when sync referenced
// - times-128 bit scales conversion pin only
// - sync-referenced gen1 ignores rate, phase, 8/7
// - modifier nibbles pick rates; 1111/1111 gives 128x
`timescale 1ns/1ps
module scgc_device
  import scgc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // power-down pin
  input wire logic power_down_n,
  // control link
  scgc_link_if.dev link,
  // generator 1
  output logic gen1_conv_tick,
  output logic gen1_ref_sync,
  output logic gen1_eight_sevenths_active,
  // generator 2 decoded mode
  output scgc_gen2_ctl_t gen2_ctl
);
  typedef struct packed {
    logic pd_meta;
    logic pd_sync;
    logic [3:0] slot_cnt;
    logic [1:0] slot_idx;
    logic slot_strobe;
    logic frame_sync;
    logic [3:0] ps_cnt;
    logic adv;
    logic ret;
    logic [15:0] gen1_mode;
    logic [15:0] gen1_rate;
    logic [15:0] gen1_phase;
    logic [15:0] gen2_mode;
    logic [15:0] pwr_ctl;
    logic [15:0] ph_snap;
    logic [1:0] resp_stage;
    logic resp_read;
    logic [5:0] resp_addr;
    logic [15:0] resp_prev;
    logic [15:0] dev_data;
    logic g1_ref;
    logic g1_x87;
    scgc_gen2_ctl_t g2;
  } scgc_dev_state_t;

  localparam scgc_dev_state_t DEV_RST = '{
    slot_idx: SLOT_FINAL,
    gen1_mode: GEN1_MODE_RST,
    gen1_rate: GEN1_RATE_RST,
    gen1_phase: PHASE_RST,
    gen2_mode: GEN2_MODE_RST,
    pwr_ctl: PWR_CTL_RST,
    resp_stage: STAGE_IDLE,
    default: '0
  };

  scgc_dev_state_t q, d;
  logic frame_start;
  logic [5:0] cmd_addr;

  function automatic logic [15:0] reg_value(
    input scgc_dev_state_t s,
    input logic [5:0] a,
    input logic [15:0] phase
  );
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      ADDR_GEN1_MODE: v = s.gen1_mode;
      ADDR_GEN1_RATE: v = s.gen1_rate;
      ADDR_GEN1_PHASE: v = phase;
      ADDR_GEN2_MODE: v = s.gen2_mode;
      ADDR_PWR_CTL: v = s.pwr_ctl;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  always_comb
  begin
    d = q;
    frame_start = q.slot_strobe && (q.slot_idx == SLOT_CTL);
    cmd_addr = link.ctl_word[ADDR_W-1:0];
    d.pd_meta = power_down_n;
    d.pd_sync = q.pd_meta;

    // slot divider
    d.slot_strobe = 1'b0;
    d.frame_sync = 1'b0;
    if (q.slot_cnt == SLOT_LAST)
    begin
      d.slot_cnt = 4'h0;
      d.slot_idx = q.slot_idx + 2'h1;
      d.slot_strobe = 1'b1;
      d.frame_sync = (q.slot_idx == SLOT_FINAL);
    end
    else
    begin
      d.slot_cnt = q.slot_cnt + 4'h1;
    end

    // phase shift processing
    d.adv = 1'b0;
    d.ret = 1'b0;
    if (q.ps_cnt == PS_TICK_LAST)
    begin
      d.ps_cnt = 4'h0;
      if (q.gen1_phase[PH_MAG_W-1:0] != '0 &&
          !q.gen1_mode[MODE_REF_BIT])
      begin
        d.gen1_phase[PH_MAG_W-1:0] =
          q.gen1_phase[PH_MAG_W-1:0] - 8'h01;
        d.adv = !q.gen1_phase[PH_DIR_BIT];
        d.ret = q.gen1_phase[PH_DIR_BIT];
      end
    end
    else
    begin
      d.ps_cnt = q.ps_cnt + 4'h1;
    end

    // slot 0: snapshot remainder, take command
    if (frame_start)
    begin
      d.ph_snap = q.gen1_phase;
      if (q.resp_stage == STAGE_CAPT)
        d.resp_stage = STAGE_DUE;
      if (link.ctl_word[CTL_VALID_BIT])
      begin
        d.resp_stage = STAGE_CAPT;
        d.resp_read = link.ctl_word[CTL_READ_BIT];
        d.resp_addr = cmd_addr;
        d.resp_prev = reg_value(q, cmd_addr, q.gen1_phase);
        if (!link.ctl_word[CTL_READ_BIT])
        begin
          case (cmd_addr)
            ADDR_GEN1_MODE: d.gen1_mode = link.host_data & MODE_WMASK;
            ADDR_GEN1_RATE: d.gen1_rate = link.host_data;
            ADDR_GEN1_PHASE:
              d.gen1_phase = link.host_data & PH_WMASK;
            ADDR_GEN2_MODE: d.gen2_mode = link.host_data & MODE_WMASK;
            ADDR_PWR_CTL: d.pwr_ctl = link.host_data;
            default: d.resp_prev = 16'h0000;
          endcase
        end
      end
    end

    // slot 1: answer of the previous frame's command
    if (q.slot_strobe && q.slot_idx == SLOT_DATA)
    begin
      d.dev_data = 16'h0000;
      if (q.resp_stage == STAGE_DUE)
      begin
        d.dev_data = q.resp_read ?
          reg_value(q, q.resp_addr, q.ph_snap) : q.resp_prev;
        d.resp_stage = STAGE_IDLE;
      end
    end

    // power-down and gen1 disable hold defaults
    if (!q.pd_sync)
    begin
      d.gen1_mode = GEN1_MODE_RST;
      d.gen1_rate = GEN1_RATE_RST;
      d.gen2_mode = GEN2_MODE_RST;
      d.pwr_ctl = PWR_CTL_RST;
    end
    if (!q.pd_sync || !q.pwr_ctl[GEN1_EN_BIT])
      d.gen1_phase = PHASE_RST;

    // decoded mode outputs
    d.g1_ref = q.gen1_mode[MODE_REF_BIT];
    d.g1_x87 = q.gen1_mode[MODE_X87_BIT] &&
               !q.gen1_mode[MODE_REF_BIT];
    d.g2.ref_sync = q.gen2_mode[MODE_REF_BIT];
    d.g2.video_lock = q.gen2_mode[MODE_REF_BIT] &&
                      q.gen2_mode[MODE_VID_BIT];
    d.g2.video_pal = q.gen2_mode[7];
    d.g2.infinite_gain = q.gen2_mode[MODE_PLLG_BIT];
    d.g2.bitclk_enable = !d.g2.video_lock;
    d.g2.bitclk_plus200 = q.gen2_mode[MODE_P200_BIT] &&
                          !d.g2.video_lock;
    d.g2.eight_sevenths = q.gen2_mode[MODE_X87_BIT] &&
                          !q.gen2_mode[MODE_REF_BIT];
    d.g2.phase_shiftable = !q.gen2_mode[MODE_REF_BIT];
    d.g2.conv_pin_x128 = q.gen2_mode[MODE_C128_BIT];
    d.g2.bitclk_x128 = !d.g2.video_lock &&
      (q.gen2_mode[7:0] == MODE_M_BOTH128);
    d.g2.bitclk_sel = q.gen2_mode[3:0];
    d.g2.conv_sel = q.gen2_mode[7:4];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= DEV_RST;
    else
      q <= d;
  end

  // gen1 rate from the accumulator, phase steps from the divider
  scgc_nco u_gen1_nco (
    .pclk(pclk),
    .presetn(presetn),
    .run(q.pd_sync && !q.gen1_mode[MODE_REF_BIT]),
    .rate(q.gen1_rate),
    .eight_sev(q.gen1_mode[MODE_X87_BIT]),
    .advance(q.adv),
    .retard(q.ret),
    .tick(gen1_conv_tick)
  );

  assign link.frame_sync = q.frame_sync;
  assign link.slot_strobe = q.slot_strobe;
  assign link.slot_index = q.slot_idx;
  assign link.dev_data = q.dev_data;
  assign gen1_ref_sync = q.g1_ref;
  assign gen1_eight_sevenths_active = q.g1_x87;
  assign gen2_ctl = q.g2;
endmodule // scgc_device

// >>> scgc_host.sv
// Purpose: host controller issuing register commands on the link
// Assumes: APB3 slave, zero wait states
// Notes: one command in flight; answer lands a frame later
`timescale 1ns/1ps
module scgc_host
  import scgc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // control link
  scgc_link_if.host link
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_ARMED = 4'b0010,
    H_SENT = 4'b0100,
    H_WAIT = 4'b1000
  } scgc_host_st_t;

  typedef struct packed {
    scgc_host_st_t st;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
    logic [15:0] ctl_word;
    logic [15:0] host_data;
    logic [31:0] prdata;
  } scgc_host_state_t;

  localparam scgc_host_state_t HOST_RST = '{st: H_IDLE, default: '0};

  scgc_host_state_t q, d;
  logic mapped;
  logic wr_acc;

  always_comb
  begin
    d = q;
    mapped = (paddr == HOST_CMD) || (paddr == HOST_WDATA) ||
             (paddr == HOST_STATUS) || (paddr == HOST_RDATA);
    wr_acc = psel && penable && pwrite;
    // read data loaded in the setup cycle
    if (psel && !penable)
    begin
      case (paddr)
        HOST_CMD: d.prdata = {16'h0000, q.ctl_word};
        HOST_WDATA: d.prdata = {16'h0000, q.wdata};
        HOST_STATUS: d.prdata = {30'h0, q.done, q.st != H_IDLE};
        HOST_RDATA: d.prdata = {16'h0000, q.rdata};
        default: d.prdata = 32'h0;
      endcase
    end
    if (wr_acc && paddr == HOST_WDATA)
      d.wdata = pwdata[15:0];
    case (q.st)
      H_IDLE:
      begin
        if (wr_acc && paddr == HOST_CMD)
        begin
          // reserved command bits always go out as zero
          d.ctl_word = {pwdata[CTL_READ_BIT], 1'b1, 8'h00,
                        pwdata[ADDR_W-1:0]};
          d.host_data = q.wdata;
          d.done = 1'b0;
          d.st = H_ARMED;
        end
      end
      H_ARMED:
      begin
        if (link.frame_sync)
        begin
          d.ctl_word = 16'h0000;
          d.st = H_SENT;
        end
      end
      H_SENT:
      begin
        if (link.frame_sync)
          d.st = H_WAIT;
      end
      H_WAIT:
      begin
        if (link.slot_strobe && link.slot_index == SLOT_CAPT)
        begin
          d.rdata = link.dev_data;
          d.done = 1'b1;
          d.st = H_IDLE;
        end
      end
      default: d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= HOST_RST;
    else
      q <= d;
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = q.prdata;
  assign link.ctl_word = q.ctl_word;
  assign link.host_data = q.host_data;
endmodule // scgc_host

// >>> scgc_link_if.sv
// Purpose: control link between device and host controller
// Assumes: both ends on pclk; device makes the frames
// Notes: four slots of sixteen cycles per frame
`timescale 1ns/1ps
interface scgc_link_if;
  logic frame_sync;
  logic slot_strobe;
  logic [1:0] slot_index;
  logic [15:0] ctl_word;
  logic [15:0] host_data;
  logic [15:0] dev_data;
  modport dev (
    output frame_sync, slot_strobe, slot_index, dev_data,
    input ctl_word, host_data
  );
  modport host (
    input frame_sync, slot_strobe, slot_index, dev_data,
    output ctl_word, host_data
  );
endinterface

// >>> scgc_link_sva.sv
// Purpose: framing and handshake checks on the control link
// Assumes: one clock domain, reset active low
// Notes: watches link signals only
`timescale 1ns/1ps
module scgc_link_sva
  import scgc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic frame_sync,
  input wire logic slot_strobe,
  input wire logic [1:0] slot_index,
  input wire logic [15:0] ctl_word,
  input wire logic [15:0] host_data,
  input wire logic [15:0] dev_data
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_strobe_period: assert property (slot_strobe |-> ##16 slot_strobe)
    else $error("slot strobe period wrong");
  a_strobe_gap: assert property (slot_strobe |=> !slot_strobe [*8])
    else $error("slot strobe too early");
  a_frame_slot0: assert property (frame_sync |->
    slot_strobe && slot_index == SLOT_CTL)
    else $error("frame sync off slot 0");
  a_ctl_to_data: assert property ((slot_strobe && slot_index == SLOT_CTL)
    |-> ##16 (slot_strobe && slot_index == SLOT_DATA))
    else $error("slot 1 does not follow slot 0");
  a_final_to_frame: assert property ((slot_strobe &&
    slot_index == SLOT_FINAL) |-> ##16 frame_sync)
    else $error("frame does not follow slot 3");
  a_cmd_taken: assert property ((frame_sync && ctl_word[CTL_VALID_BIT])
    |=> !ctl_word[CTL_VALID_BIT] [*8])
    else $error("command not withdrawn");
  a_arm_bound: assert property ($rose(ctl_word[CTL_VALID_BIT])
    |-> ##[1:64] frame_sync)
    else $error("armed command not framed");
  a_ctl_hold: assert property ((ctl_word[CTL_VALID_BIT] && !frame_sync)
    |=> $stable(ctl_word) && $stable(host_data))
    else $error("command changed while armed");
  a_answer_slot1: assert property (!$stable(dev_data) |->
    $past(slot_strobe) && $past(slot_index) == SLOT_DATA)
    else $error("answer moved outside slot 1");
  c_write: cover property (frame_sync && ctl_word[CTL_VALID_BIT]
    && !ctl_word[CTL_READ_BIT]);
  c_read: cover property (frame_sync && ctl_word[CTL_VALID_BIT]
    && ctl_word[CTL_READ_BIT]);
  c_slot3: cover property (slot_strobe && slot_index == SLOT_FINAL);
endmodule // scgc_link_sva

// >>> scgc_nco.sv
// Purpose: conversion-rate tick generator, one hertz per rate step
// Assumes: pclk at CLK_HZ
// Notes: advance or retard moves the phase by 1/3000 of a period
`timescale 1ns/1ps
module scgc_nco
  import scgc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic [15:0] rate,
  input wire logic eight_sev,
  input wire logic advance,
  input wire logic retard,
  // output
  output logic tick
);
  typedef struct packed {
    logic [31:0] acc;
    logic tick;
  } scgc_nco_state_t;

  scgc_nco_state_t q, d;
  logic [31:0] inc;
  logic [31:0] t;

  always_comb
  begin
    d = q;
    inc = {16'h0000, rate} * 32'(eight_sev ? NCO_MUL_87 : NCO_MUL_NORM);
    // offset by one modulus so a retard never goes negative
    t = q.acc + inc + NCO_MOD + (advance ? PH_STEP : 32'h0)
        - (retard ? PH_STEP : 32'h0);
    d.tick = 1'b0;
    if (!run)
    begin
      d.acc = 32'h0;
    end
    else if (t >= (NCO_MOD << 1))
    begin
      d.acc = t - (NCO_MOD << 1);
      d.tick = 1'b1;
    end
    else if (t < NCO_MOD)
    begin
      // retard bigger than one cycle's advance: hold at zero
      d.acc = 32'h0;
    end
    else
    begin
      d.acc = t - NCO_MOD;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign tick = q.tick;
endmodule // scgc_nco

// >>> scgc_pkg.sv
// Purpose: shared constants and types of the sample clock control block
// Assumes: pclk at 40 MHz stands in for the master clock input
// Notes: link is word-parallel, slotted, device is frame master
package scgc_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int PS_RATE_HZ = 3_072_000;
  localparam int PS_TICK_CYC = CLK_HZ / PS_RATE_HZ;
  localparam logic [3:0] PS_TICK_LAST = 4'(PS_TICK_CYC - 1);
  // rate accumulator: modulus 21 * clock keeps 8/7 and phase steps exact
  localparam int NCO_MUL_NORM = 21;
  localparam int NCO_MUL_87 = 24;
  localparam logic [31:0] NCO_MOD = 32'(CLK_HZ * NCO_MUL_NORM);
  localparam int PH_STEPS_PER_CYCLE = 3000;
  localparam logic [31:0] PH_STEP = 32'(CLK_HZ * NCO_MUL_NORM
                                        / PH_STEPS_PER_CYCLE);
  // register indices on the link
  localparam int ADDR_W = 6;
  localparam logic [5:0] ADDR_GEN1_MODE = 6'h10;
  localparam logic [5:0] ADDR_GEN1_RATE = 6'h11;
  localparam logic [5:0] ADDR_GEN1_PHASE = 6'h12;
  localparam logic [5:0] ADDR_GEN2_MODE = 6'h13;
  localparam logic [5:0] ADDR_PWR_CTL = 6'h1C;
  localparam logic [15:0] GEN1_MODE_RST = 16'h00FF;
  localparam logic [15:0] GEN1_RATE_RST = 16'hBB80;
  localparam logic [15:0] PHASE_RST = 16'h0000;
  localparam logic [15:0] GEN2_MODE_RST = 16'h00FF;
  localparam logic [15:0] PWR_CTL_RST = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'hFCFF;
  localparam logic [15:0] PH_WMASK = 16'h01FF;
  localparam int MODE_REF_BIT = 15;
  localparam int MODE_VID_BIT = 14;
  localparam int MODE_PLLG_BIT = 13;
  localparam int MODE_P200_BIT = 12;
  localparam int MODE_X87_BIT = 11;
  localparam int MODE_C128_BIT = 10;
  localparam logic [7:0] MODE_M_BOTH128 = 8'hFF;
  localparam int PH_DIR_BIT = 8;
  localparam int PH_MAG_W = 8;
  localparam int GEN1_EN_BIT = 0;
  // link framing
  localparam logic [3:0] SLOT_LAST = 4'hF;
  localparam logic [1:0] SLOT_CTL = 2'h0;
  localparam logic [1:0] SLOT_DATA = 2'h1;
  localparam logic [1:0] SLOT_CAPT = 2'h2;
  localparam logic [1:0] SLOT_FINAL = 2'h3;
  localparam int CTL_READ_BIT = 15;
  localparam int CTL_VALID_BIT = 14;
  localparam logic [1:0] STAGE_IDLE = 2'h0;
  localparam logic [1:0] STAGE_CAPT = 2'h1;
  localparam logic [1:0] STAGE_DUE = 2'h2;
  // host APB map
  localparam logic [11:0] HOST_CMD = 12'h000;
  localparam logic [11:0] HOST_WDATA = 12'h004;
  localparam logic [11:0] HOST_STATUS = 12'h008;
  localparam logic [11:0] HOST_RDATA = 12'h00C;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  typedef struct packed {
    logic ref_sync;
    logic video_lock;
    logic video_pal;
    logic infinite_gain;
    logic bitclk_enable;
    logic bitclk_plus200;
    logic eight_sevenths;
    logic phase_shiftable;
    logic conv_pin_x128;
    logic bitclk_x128;
    logic [3:0] bitclk_sel;
    logic [3:0] conv_sel;
  } scgc_gen2_ctl_t;
endpackage

// >>> tb_top.sv
// Purpose: self-checking bench of host and device across the link
// Assumes: APB master in the bench, fixed random seed
// Notes: expectations computed from register rules
`timescale 1ns/1ps
module tb_top
  import scgc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic power_down_n = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic gen1_conv_tick;
  logic gen1_ref_sync;
  logic gen1_eight_sevenths_active;
  scgc_gen2_ctl_t gen2_ctl;
  int failures = 0;
  int check_count = 0;
  int seed;
  int n;
  logic [31:0] r;
  logic e;
  logic [15:0] a;
  logic [15:0] v;
  logic [15:0] prev;
  logic [15:0] corner [5] = '{16'h0000, 16'hC0FF, 16'h80FF, 16'h7CFF,
                               16'hBCAF};

  scgc_link_if link ();
  scgc_device u_scgc_device (.pclk(pclk), .presetn(presetn),
    .power_down_n(power_down_n), .link(link.dev),
    .gen1_conv_tick(gen1_conv_tick), .gen1_ref_sync(gen1_ref_sync),
    .gen1_eight_sevenths_active(gen1_eight_sevenths_active),
    .gen2_ctl(gen2_ctl));
  scgc_host u_scgc_host (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .link(link.host));
  scgc_link_sva u_scgc_link_sva (.pclk(pclk), .presetn(presetn),
    .frame_sync(link.frame_sync), .slot_strobe(link.slot_strobe),
    .slot_index(link.slot_index), .ctl_word(link.ctl_word),
    .host_data(link.host_data), .dev_data(link.dev_data));

  always #12.5 pclk = ~pclk;

  task automatic report_and_stop();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hung();
    failures++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    report_and_stop();
  endtask

  task automatic apb(input logic [11:0] ad, input logic w,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= ad;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (k >= 16)
      hung();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one link command, waits for the answer
  task automatic cmd(input logic [5:0] idx, input logic rd,
                     input logic [15:0] d, output logic [15:0] ans);
    logic [31:0] q;
    logic qe;
    int k;
    apb(HOST_WDATA, 1'b1, {16'h0000, d}, q, qe);
    apb(HOST_CMD, 1'b1, {16'h0000, rd, 9'h000, idx}, q, qe);
    k = 0;
    do
    begin
      apb(HOST_STATUS, 1'b0, 32'h0, q, qe);
      k++;
    end
    while (q[STAT_DONE_BIT] !== 1'b1 && k < 100);
    if (k >= 100)
      hung();
    apb(HOST_RDATA, 1'b0, 32'h0, q, qe);
    ans = q[15:0];
  endtask

  task automatic rw(input logic [5:0] idx, input logic rd,
                    input logic [15:0] d, input logic [15:0] exp);
    logic [15:0] ans;
    cmd(idx, rd, d, ans);
    chk({16'h0000, ans}, {16'h0000, exp});
  endtask

  task automatic ticks(input int cyc, output int c);
    c = 0;
    repeat (cyc)
    begin
      @(posedge pclk);
      if (gen1_conv_tick === 1'b1)
        c++;
    end
  endtask

  function automatic scgc_gen2_ctl_t dec2(input logic [15:0] m);
    scgc_gen2_ctl_t c;
    logic vid;
    vid = m[15] & m[14];
    c.ref_sync = m[15];
    c.video_lock = vid;
    c.video_pal = m[7];
    c.infinite_gain = m[13];
    c.bitclk_enable = !vid;
    c.bitclk_plus200 = m[12] & !vid;
    c.eight_sevenths = m[11] & !m[15];
    c.phase_shiftable = !m[15];
    c.conv_pin_x128 = m[10];
    c.bitclk_x128 = !vid && m[7:0] == 8'hFF;
    c.bitclk_sel = m[3:0];
    c.conv_sel = m[7:4];
    return c;
  endfunction

  initial
  begin
    seed = 32'hd54f;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rw(ADDR_GEN1_MODE, 1'b1, 16'h0000, 16'h00FF);
    rw(ADDR_GEN1_RATE, 1'b1, 16'h0000, 16'hBB80);
    rw(ADDR_GEN1_PHASE, 1'b1, 16'h0000, 16'h0000);
    apb(12'h010, 1'b0, 32'h0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test reset values done");
    power_down_n <= 1'b0;
    repeat (6) @(posedge pclk);
    rw(ADDR_GEN1_RATE, 1'b0, 16'h1234, 16'hBB80);
    rw(ADDR_GEN1_MODE, 1'b0, 16'h8000, 16'h00FF);
    rw(ADDR_GEN1_RATE, 1'b1, 16'h0000, 16'hBB80);
    rw(ADDR_GEN1_MODE, 1'b1, 16'h0000, 16'h00FF);
    power_down_n <= 1'b1;
    repeat (6) @(posedge pclk);
    $display("test power down done");
    rw(ADDR_GEN1_PHASE, 1'b0, 16'h0155, 16'h0000);
    rw(ADDR_GEN1_PHASE, 1'b1, 16'h0000, 16'h0000);
    rw(ADDR_PWR_CTL, 1'b0, 16'h0001, 16'h0000);
    rw(ADDR_GEN1_PHASE, 1'b0, 16'h01FF, 16'h0000);
    cmd(ADDR_GEN1_PHASE, 1'b1, 16'h0000, a);
    chk(a[8], 1);
    chk(a[7:0] < 8'hFF && a[7:0] > 8'h80, 1);
    cmd(ADDR_GEN1_PHASE, 1'b0, 16'h0005, a);
    chk(a[15:8], 8'h01);
    rw(ADDR_GEN1_PHASE, 1'b1, 16'h0000, 16'h0000);
    $display("test phase shift done");
    r = $random(seed);
    v = 16'h0FA0 + 16'(r[15:0] % 16'hC351);
    rw(ADDR_GEN1_RATE, 1'b0, v, 16'hBB80);
    rw(ADDR_GEN1_RATE, 1'b1, 16'h0000, v);
    rw(ADDR_GEN1_RATE, 1'b0, 16'hD2F0, v);
    ticks(7408, n);
    chk(n >= 10 && n <= 11, 1);
    rw(ADDR_GEN1_MODE, 1'b0, 16'h8800, 16'h00FF);
    chk({gen1_ref_sync, gen1_eight_sevenths_active}, 2'b10);
    ticks(2000, n);
    chk(n, 0);
    rw(ADDR_GEN1_MODE, 1'b0, 16'h0800, 16'h8800);
    chk({gen1_ref_sync, gen1_eight_sevenths_active}, 2'b01);
    ticks(7408, n);
    chk(n >= 11 && n <= 12, 1);
    $display("test gen1 rate done");
    prev = 16'h00FF;
    for (int i = 0; i < 11; i++)
    begin
      r = $random(seed);
      v = (i < 5) ? corner[i] : r[15:0] & MODE_WMASK;
      rw(ADDR_GEN2_MODE, 1'b0, v, prev);
      chk(32'(gen2_ctl), 32'(dec2(v)));
      prev = v;
    end
    $display("test gen2 mode done");
    report_and_stop();
  end
endmodule // tb_top
